// ### core/acst_top.sv
// Converter sequencer: timing, result coding, over-range flags and done pin.
// Assumes host strobes arrive on link_clk and setup words are quasi-static on sys_clk.
`timescale 1ns/1ps
`include "acst_defines.svh"
module acst_top #(
    parameter int PIPE_CYC   = `ACST_PIPE_CYC,
    parameter int FAST_CYC   = `ACST_FAST_CYC,
    parameter int SLOW_CYC   = `ACST_SLOW_CYC,
    parameter int SWITCH_CYC = `ACST_SWITCH_CYC,
    parameter int RDY_CYC    = `ACST_RDY_CYC
) (
    // Oscillator clock domain
    input  wire logic                             sys_clk,
    input  wire logic                             rst,
    // Host link domain
    input  wire logic                             link_clk,
    input  wire logic                             link_rst,
    input  wire logic                             host_ctrl_wr,
    input  wire logic                             host_alt_wr,
    input  wire logic                             host_rdy_clr,
    input  wire logic                             host_ovr_clr,
    input  wire acst_pkg::acst_cmd_t              host_cmd,
    // Per-channel setup and fault mask
    input  wire acst_pkg::acst_chcfg_t [3:0]      ch_cfg,
    input  wire logic [7:0]                       fault_mask,
    // Front-end sample, full-scale of the span is 65535
    input  wire logic signed [18:0]               fe_sample,
    output logic [2:0]                            fe_sel,
    // Results and status
    output logic [3:0][15:0]                      channel_result,
    output logic [3:0][15:0]                      diagnostic_result,
    output logic [7:0]                            conversion_overrange_flag,
    output logic                                  result_ready,
    output logic                                  conv_done_n,
    output logic                                  fault_n
);
    localparam int RDY_HI = RDY_CYC;

    acst_pkg::acst_link_t lk_r;
    acst_pkg::acst_link_t lk_nxt;
    acst_pkg::acst_sys_t  q_r;
    acst_pkg::acst_sys_t  q_nxt;
    logic [3:0]           tgl_s;
    acst_pkg::acst_cmd_t  cmd_s;

    // Host strobes become toggles held on the link clock
    always_comb begin
        lk_nxt = lk_r;
        if (host_ctrl_wr) begin
            lk_nxt.tgl[0] = ~lk_r.tgl[0];
            lk_nxt.cmd    = host_cmd;
        end
        if (host_alt_wr) begin
            lk_nxt.tgl[1] = ~lk_r.tgl[1];
        end
        if (host_rdy_clr) begin
            lk_nxt.tgl[2] = ~lk_r.tgl[2];
        end
        if (host_ovr_clr) begin
            lk_nxt.tgl[3] = ~lk_r.tgl[3];
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    acst_sync #(.W(4)) u_tgl_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (lk_r.tgl),
        .q   (tgl_s)
    );

    acst_sync #(.W($bits(acst_pkg::acst_cmd_t))) u_cmd_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (lk_r.cmd),
        .q   (cmd_s)
    );

    // Codes one sample for its span and source; bit 16 flags out of range
    function automatic logic [16:0] encode(logic [2:0] span, logic src,
                                           logic signed [18:0] s);
        logic signed [19:0] v;
        logic [15:0]        top;
        v   = {s[18], s};
        top = `ACST_CODE_MAX;
        case (span)
            `ACST_SPAN_0_10: begin
                if (src == `ACST_SRC_SENSE) begin
                    v   = v >>> 2;
                    top = `ACST_CODE_I10_MAX;
                end
            end
            `ACST_SPAN_0_P25: v = v;
            `ACST_SPAN_0_N25: v = -v;
            `ACST_SPAN_BIP:   v = (v + `ACST_BIP_OFFSET) >>> 1;
            default:          v = v;
        endcase
        if (v < 0) begin
            encode = {1'b1, `ACST_CODE_ZERO};
        end else if (v > $signed({4'h0, top})) begin
            encode = {1'b1, `ACST_CODE_MAX};
        end else begin
            encode = {1'b0, v[15:0]};
        end
    endfunction

    // Lowest enabled input at or above lo; bit 3 says one was found
    function automatic logic [3:0] pick(logic [7:0] en, int lo);
        pick = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && i >= lo) begin
                pick = {1'b1, 3'(i)};
            end
        end
    endfunction

    // Conversion length of an input from its channel rate, or from the shared diagnostic rate for inputs 4 to 7
    function automatic logic [20:0] conv_len(acst_pkg::acst_chcfg_t [3:0] cfg,
                                             logic drate, logic [2:0] idx);
        logic r;
        r = idx[2] ? drate : cfg[idx[1:0]].rate;
        conv_len = (r == `ACST_RATE_SLOW) ? 21'(SLOW_CYC - 1)
                                          : 21'(FAST_CYC - 1);
    endfunction

    logic [3:0]  ev;
    logic [7:0]  en;
    logic        multi;
    logic [3:0]  nxt_in;
    logic [3:0]  first_in;
    logic [3:0]  first_cmd;
    logic [16:0] coded;
    logic        seq_end;
    logic        rdy_rel;

    always_comb begin
        q_nxt          = q_r;
        ev             = tgl_s ^ q_r.tgl_prev;
        q_nxt.tgl_prev = tgl_s;
        // Data settles one cycle behind its toggle
        q_nxt.ctl_pend = ev[0];
        if (q_r.ctl_pend) begin
            q_nxt.cmd = cmd_s;
        end
        en       = {q_r.cmd.diag_en, q_r.cmd.ch_en};
        multi    = |(en & (en - 8'h01));
        first_in = pick(en, 0);
        nxt_in   = pick(en, int'(q_r.cur) + 1);
        first_cmd = pick({cmd_s.diag_en, cmd_s.ch_en}, 0);
        coded    = encode(q_r.cur[2] ? `ACST_SPAN_0_P25 : ch_cfg[q_r.cur[1:0]].span,
                          q_r.cur[2] ? `ACST_SRC_TERM : ch_cfg[q_r.cur[1:0]].src,
                          fe_sample);
        seq_end  = 1'b0;
        q_nxt.cnt = q_r.cnt - 21'h000001;
        case (q_r.st)
            acst_pkg::ST_IDLE: begin
                q_nxt.cnt = '0;
                if (q_r.ctl_pend && (cmd_s.mode == `ACST_MODE_SINGLE ||
                                     cmd_s.mode == `ACST_MODE_CONT) &&
                    (|{cmd_s.diag_en, cmd_s.ch_en})) begin
                    q_nxt.st  = acst_pkg::ST_PIPE;
                    q_nxt.cnt = 21'(PIPE_CYC - 1);
                end
            end
            acst_pkg::ST_PIPE, acst_pkg::ST_SWITCH: begin
                if (q_r.cnt == '0) begin
                    q_nxt.st  = acst_pkg::ST_CONV;
                    q_nxt.cnt = conv_len(ch_cfg, q_r.cmd.diag_rate, q_r.cur);
                end
            end
            acst_pkg::ST_CONV: begin
                if (q_r.cnt == '0) begin
                    q_nxt.stage[q_r.cur] = coded[15:0];
                    q_nxt.ovr[q_r.cur]   = q_r.ovr[q_r.cur] | coded[16];
                    if (nxt_in[3]) begin
                        q_nxt.st  = acst_pkg::ST_SWITCH;
                        q_nxt.cur = nxt_in[2:0];
                        q_nxt.cnt = 21'(SWITCH_CYC - 1);
                    end else begin
                        seq_end = 1'b1;
                        if (q_r.cmd.mode == `ACST_MODE_CONT && first_in[3]) begin
                            q_nxt.cur = first_in[2:0];
                            if (multi) begin
                                q_nxt.st  = acst_pkg::ST_SWITCH;
                                q_nxt.cnt = 21'(SWITCH_CYC - 1);
                            end else begin
                                q_nxt.cnt = conv_len(ch_cfg, q_r.cmd.diag_rate,
                                                     first_in[2:0]);
                            end
                        end else begin
                            q_nxt.st = acst_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                q_nxt.st = acst_pkg::ST_IDLE;
            end
        endcase
        if (q_r.st == acst_pkg::ST_IDLE) begin
            q_nxt.cur = first_in[2:0];
            if (q_r.ctl_pend) begin
                q_nxt.cur = first_cmd[2:0];
            end
        end
        // Results move together only at a sequence end
        if (seq_end) begin
            q_nxt.ch_res = q_nxt.stage[3:0];
            q_nxt.dg_res = q_nxt.stage[7:4];
        end
        // Done pin release, then a new end wins over any release
        rdy_rel = ev[2] | ev[0] | ev[1];
        if (q_r.rdy_cont && !q_r.done_n) begin
            if (q_r.rdy_cnt == '0) begin
                rdy_rel = 1'b1;
            end else begin
                q_nxt.rdy_cnt = q_r.rdy_cnt - 10'h001;
            end
        end
        if (rdy_rel) begin
            q_nxt.done_n   = 1'b1;
            q_nxt.rdy      = 1'b0;
            q_nxt.rdy_cont = 1'b0;
        end
        if (seq_end) begin
            q_nxt.done_n   = 1'b0;
            q_nxt.rdy      = 1'b1;
            q_nxt.rdy_cont = (q_r.cmd.mode == `ACST_MODE_CONT);
            q_nxt.rdy_cnt  = 10'(RDY_CYC - 1);
        end
        if (ev[3]) begin
            q_nxt.ovr = '0;
            if (q_r.st == acst_pkg::ST_CONV && q_r.cnt == '0) begin
                q_nxt.ovr[q_r.cur] = coded[16];
            end
        end
        q_nxt.alert_n = ~|(q_nxt.ovr & ~fault_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_r          <= '0;
            q_r.st       <= acst_pkg::ST_IDLE;
            q_r.alert_n  <= 1'b1;
            q_r.done_n   <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign fe_sel                    = q_r.cur;
    assign channel_result            = q_r.ch_res;
    assign diagnostic_result         = q_r.dg_res;
    assign conversion_overrange_flag = q_r.ovr;
    assign result_ready              = q_r.rdy;
    assign conv_done_n               = q_r.done_n;
    assign fault_n                   = q_r.alert_n;

    // Cycles spent so far in the present state, restarted with each conversion
    logic [20:0] dwell_r;
    always_ff @(posedge sys_clk) begin
        if (rst || q_nxt.st != q_r.st ||
            (q_r.st == acst_pkg::ST_CONV && q_r.cnt == '0)) begin
            dwell_r <= '0;
        end else begin
            dwell_r <= dwell_r + 21'h000001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_pipe_len;
        (q_r.st == acst_pkg::ST_PIPE && q_nxt.st != acst_pkg::ST_PIPE)
            |-> dwell_r == 21'(PIPE_CYC - 1);
    endproperty
    a_pipe_len: assert property (p_pipe_len) else $error("pipeline delay length wrong");

    property p_conv_len;
        (q_r.st == acst_pkg::ST_CONV && q_r.cnt == '0 && dwell_r != '0)
            |-> dwell_r == conv_len(ch_cfg, q_r.cmd.diag_rate, q_r.cur);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_switch_len;
        (q_r.st == acst_pkg::ST_SWITCH && q_nxt.st != acst_pkg::ST_SWITCH)
            |-> dwell_r == 21'(SWITCH_CYC - 1);
    endproperty
    a_switch_len: assert property (p_switch_len) else $error("switch time wrong");

    property p_done_commit;
        $fell(conv_done_n) |-> channel_result == q_r.stage[3:0] && result_ready;
    endproperty
    a_done_commit: assert property (p_done_commit) else $error("results not moved");

    property p_hold;
        !(q_r.st == acst_pkg::ST_CONV && q_r.cnt == '0)
            |=> $stable(channel_result) && $stable(diagnostic_result);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed mid sequence");

    property p_cont_release;
        ($fell(conv_done_n) && q_r.rdy_cont) |-> ##[1:RDY_HI] conv_done_n;
    endproperty
    a_cont_release: assert property (p_cont_release) else $error("done not released");

    property p_clr_release;
        (ev[2] && !seq_end) |=> conv_done_n && !result_ready;
    endproperty
    a_clr_release: assert property (p_clr_release) else $error("clear ignored");

    property p_single_idle;
        (seq_end && q_r.cmd.mode != `ACST_MODE_CONT) |=> q_r.st == acst_pkg::ST_IDLE;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single did not idle");

    property p_order;
        (q_r.st == acst_pkg::ST_CONV) |-> en[q_r.cur];
    endproperty
    a_order: assert property (p_order) else $error("disabled input converted");

    property p_fault;
        (|(q_r.ovr & ~fault_mask) && !ev[3]) |=> !fault_n;
    endproperty
    a_fault: assert property (p_fault) else $error("fault pin not asserted");

    c_single: cover property ($fell(conv_done_n) && !q_r.rdy_cont);
    c_cont:   cover property ($fell(conv_done_n) && q_r.rdy_cont);
    c_ovr:    cover property ($rose(q_r.ovr[0]));
    c_switch: cover property (q_r.st == acst_pkg::ST_SWITCH);

endmodule

// ### core/acst_defines.svh
// Constants of the converter sequencing, timing and ready block.
// Assumes a 25 MHz system clock that stands in for the on-chip oscillator.
// Overview of operation
// - Two conversion rates: fast 4.8 kSPS without mains rejection, slow 20 SPS with it.
// - Each of the four channels picks its own rate in its setup word.
// - One diagnostic rate from conversion control serves every enabled diagnostic input.
// - After the start command wait the 74 us pipeline delay before converting.
// - One conversion lasts 208.33 us fast or 50 ms slow.
// - With several inputs enabled, insert 24.4 us switch time at each input change.
// - Continuous period equals the sum of switch plus conversion per enabled input.
// - All timing counts derive from the oscillator clock and scale with it.
// - Drive the done pin low at the end of every whole sequence.
// - Host writing one to the ready flag releases the done pin.
// - In continuous mode release the done pin 24 us after asserting it.
// - Any write to conversion control or its alternate register releases done.
// - Span 000, terminal voltage: 0x0000 at 0 V up to 0xFFFF at 10 V.
// - Span 000, sense resistor: 0x0000 at 0 mA up to 0x3FFF at 25 mA.
// - Span 001: 0x0000 at zero to 0xFFFF at +2.5 V or 25 mA inward.
// - Span 010: 0x0000 at zero to 0xFFFF at -2.5 V or 25 mA outward.
// - Span 011: offset binary, 0x0000 negative, 0x8000 zero, 0xFFFF positive full scale.
// - Source 0 measures terminal voltage, source 1 the sense resistor voltage.
// - Out of range clamps to 0xFFFF or zero, sets over-range flag, asserts fault.
// - Fault mask stops a masked over-range flag from driving the fault pin.
// - Convert enabled channels low to high, then diagnostics; single idles, continuous repeats.
// - At sequence end move all results into result registers with done assertion.
`ifndef ACST_DEFINES_SVH
`define ACST_DEFINES_SVH

`define ACST_CLK_NS        40
`define ACST_T_PIPE_NS     74000
`define ACST_T_FAST_NS     208330
`define ACST_T_SLOW_NS     50000000
`define ACST_T_SWITCH_NS   24400
`define ACST_T_RDY_NS      24000
`define ACST_CEIL_CYC(t)   (((t) + `ACST_CLK_NS - 1) / `ACST_CLK_NS)
`define ACST_FLOOR_CYC(t)  ((t) / `ACST_CLK_NS)
`define ACST_PIPE_CYC      `ACST_CEIL_CYC(`ACST_T_PIPE_NS)
`define ACST_FAST_CYC      `ACST_CEIL_CYC(`ACST_T_FAST_NS)
`define ACST_SLOW_CYC      `ACST_CEIL_CYC(`ACST_T_SLOW_NS)
`define ACST_SWITCH_CYC    `ACST_CEIL_CYC(`ACST_T_SWITCH_NS)
`define ACST_RDY_CYC       `ACST_FLOOR_CYC(`ACST_T_RDY_NS)

`define ACST_MODE_IDLE     2'h0
`define ACST_MODE_SINGLE   2'h1
`define ACST_MODE_CONT     2'h2
`define ACST_MODE_PDOWN    2'h3
`define ACST_RATE_FAST     1'h0
`define ACST_RATE_SLOW     1'h1
`define ACST_SRC_TERM      1'h0
`define ACST_SRC_SENSE     1'h1
`define ACST_SPAN_0_10     3'h0
`define ACST_SPAN_0_P25    3'h1
`define ACST_SPAN_0_N25    3'h2
`define ACST_SPAN_BIP      3'h3
`define ACST_CODE_MAX      16'hFFFF
`define ACST_CODE_ZERO     16'h0000
`define ACST_CODE_I10_MAX  16'h3FFF
`define ACST_BIP_OFFSET    20'sh10000
`define ACST_N_CH          4
`define ACST_N_IN          8

`endif

// ### core/acst_pkg.sv
// Types shared by the converter sequencing, timing and ready block.
// Assumes the constants header is compiled alongside.
package acst_pkg;

    typedef struct packed {
        logic       rate;
        logic       src;
        logic [2:0] span;
    } acst_chcfg_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] ch_en;
        logic [3:0] diag_en;
        logic       diag_rate;
    } acst_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_PIPE   = 4'h2,
        ST_SWITCH = 4'h4,
        ST_CONV   = 4'h8
    } acst_state_t;

    typedef struct packed {
        acst_state_t           st;
        logic [20:0]           cnt;
        logic [2:0]            cur;
        acst_cmd_t             cmd;
        logic [3:0]            tgl_prev;
        logic                  ctl_pend;
        logic [7:0][15:0]      stage;
        logic [3:0][15:0]      ch_res;
        logic [3:0][15:0]      dg_res;
        logic [7:0]            ovr;
        logic                  alert_n;
        logic                  done_n;
        logic                  rdy;
        logic                  rdy_cont;
        logic [9:0]            rdy_cnt;
    } acst_sys_t;

    typedef struct packed {
        logic [3:0] tgl;
        acst_cmd_t  cmd;
    } acst_link_t;

endpackage

// ### core/acst_sync.sv
// Three-stage synchroniser for a bus of levels.
// Assumes each bit is held stable for several destination clocks.
`timescale 1ns/1ps
module acst_sync #(
    parameter int W = 1
) (
    // Destination clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels in and filtered levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } acst_sync_t;

    acst_sync_t r_r;
    acst_sync_t r_nxt;

    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = d;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        // A change counts only once the last two stages agree
        for (int i = 0; i < W; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.q[i] = r_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign q = r_r.q;

endmodule

// ### test/acst_host_model.sv
// Host model: issues the four host strobes and the command word on link_clk.
// Assumes link_clk runs free and strobes are spaced wide enough to pass the sync.
`timescale 1ns/1ps
module acst_host_model (
    // Host link clock
    input  wire logic           link_clk,
    // Strobes and command word
    output logic                host_ctrl_wr,
    output logic                host_alt_wr,
    output logic                host_rdy_clr,
    output logic                host_ovr_clr,
    output acst_pkg::acst_cmd_t host_cmd
);
    initial begin
        {host_ctrl_wr, host_alt_wr, host_rdy_clr, host_ovr_clr} = 4'h0;
        host_cmd = '0;
    end
    // One-cycle strobe, then a quiet gap so two strobes never merge
    task automatic send(input int kind, input acst_pkg::acst_cmd_t c);
        @(posedge link_clk);
        #1;
        host_cmd = c;
        case (kind)
            0: host_ctrl_wr = 1'b1;
            1: host_alt_wr = 1'b1;
            2: host_rdy_clr = 1'b1;
            default: host_ovr_clr = 1'b1;
        endcase
        @(posedge link_clk);
        #1;
        {host_ctrl_wr, host_alt_wr, host_rdy_clr, host_ovr_clr} = 4'h0;
        repeat (40) @(posedge link_clk);
    endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the converter sequencer with shortened timing counts.
// Assumes the host model drives the link side and fe_sample follows fe_sel.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [3:0][15:0] ch;
        logic [3:0][15:0] dg;
        logic [7:0]       fl;
        logic             flt_n;
    } acst_tb_exp_t;
    localparam int P_PIPE = 8, P_FAST = 20, P_SLOW = 40, P_SW = 5, P_RDY = 6;
    logic                        sys_clk = 1'b0;
    logic                        link_clk = 1'b0;
    logic                        rst = 1'b1;
    logic                        link_rst = 1'b1;
    logic                        host_ctrl_wr, host_alt_wr, host_rdy_clr, host_ovr_clr;
    acst_pkg::acst_cmd_t         host_cmd, cmd;
    acst_pkg::acst_chcfg_t [3:0] ch_cfg = '0;
    logic [7:0]                  fault_mask = 8'h00;
    logic signed [18:0]          fe_sample = '0;
    logic signed [18:0]          samp [8];
    logic [2:0]                  fe_sel;
    logic [3:0][15:0]            channel_result, diagnostic_result;
    logic [7:0]                  conversion_overrange_flag;
    logic                        result_ready, conv_done_n, fault_n;
    acst_tb_exp_t                exp_q [$];
    acst_tb_exp_t                e;
    int                          err_count = 0;
    int                          samples_checked = 0;
    int                          n, nl, nh;

    always #20 sys_clk = ~sys_clk;
    always #7.5 link_clk = ~link_clk;

    acst_top #(.PIPE_CYC(P_PIPE), .FAST_CYC(P_FAST), .SLOW_CYC(P_SLOW),
               .SWITCH_CYC(P_SW), .RDY_CYC(P_RDY)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
        .host_ctrl_wr(host_ctrl_wr), .host_alt_wr(host_alt_wr),
        .host_rdy_clr(host_rdy_clr), .host_ovr_clr(host_ovr_clr), .host_cmd(host_cmd),
        .ch_cfg(ch_cfg), .fault_mask(fault_mask), .fe_sample(fe_sample), .fe_sel(fe_sel),
        .channel_result(channel_result), .diagnostic_result(diagnostic_result),
        .conversion_overrange_flag(conversion_overrange_flag),
        .result_ready(result_ready), .conv_done_n(conv_done_n), .fault_n(fault_n));

    acst_host_model u_host (
        .link_clk(link_clk), .host_ctrl_wr(host_ctrl_wr), .host_alt_wr(host_alt_wr),
        .host_rdy_clr(host_rdy_clr), .host_ovr_clr(host_ovr_clr), .host_cmd(host_cmd));

    // Front end answers with the value prepared for the selected input
    always @(posedge sys_clk) #1 fe_sample <= samp[fe_sel];

    task automatic chk_val(input string what, input logic [63:0] ev, input logic [63:0] gv);
        samples_checked++;
        if (gv !== ev) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, ev, gv);
        end
    endtask
    task automatic chk_pin(input string what, input logic ev, input logic gv);
        samples_checked++;
        if (gv !== ev) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, ev, gv);
        end
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_done(input logic lvl, output int k);
        k = 0;
        while (conv_done_n !== lvl && k < 3000) begin
            tick(1);
            k++;
        end
        if (k >= 3000) err_count++;
    endtask
    // One single pass over all channels and diagnostic 0, which is over range
    task automatic run_single(input logic [7:0] mask);
        logic [15:0] r0, r1;
        r0 = 16'($urandom_range(0, 65535));
        r1 = 16'($urandom_range(0, 65535));
        samp[0] = 19'(r0);
        samp[1] = 19'(r1);
        samp[3] = -samp[0];
        samp[4] = 19'sd70000;
        fault_mask = mask;
        exp_q.push_back('{ch: {r0, 16'h8000, {2'b00, r1[15:2]}, r0},
                          dg: {48'h0, 16'hFFFF}, fl: 8'h10, flt_n: mask[4]});
        cmd = '{mode: 2'h1, ch_en: 4'hF, diag_en: 4'h1, diag_rate: 1'b1};
        u_host.send(0, cmd);
        wait_done(1'b0, n);
        tick(20);
        chk_pin("done held in single", 1'b0, conv_done_n);
    endtask

    // Results are compared once the done pin has fallen
    always begin
        @(negedge conv_done_n);
        tick(1);
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk_val("channel_result", 64'(e.ch),
                    64'(channel_result));
            chk_val("diagnostic_result", 64'(e.dg),
                    64'(diagnostic_result));
            chk_val("overrange flags", 64'(e.fl), 64'(conversion_overrange_flag));
            chk_pin("fault_n", e.flt_n, fault_n);
            chk_pin("result_ready", 1'b1, result_ready);
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 8; i++) samp[i] = '0;
        void'($urandom(53));
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        link_rst = 1'b0;
        tick(6);
        ch_cfg[0] = '{rate: 1'b0, src: 1'b0, span: 3'h0};
        ch_cfg[1] = '{rate: 1'b1, src: 1'b1, span: 3'h0};
        ch_cfg[2] = '{rate: 1'b0, src: 1'b0, span: 3'h3};
        ch_cfg[3] = '{rate: 1'b1, src: 1'b0, span: 3'h2};
        run_single(8'h00);
        u_host.send(2, cmd);
        tick(10);
        chk_pin("done after ready clear", 1'b1, conv_done_n);
        u_host.send(3, cmd);
        tick(10);
        chk_val("flags after clear", 64'h0, 64'(conversion_overrange_flag));
        chk_pin("fault_n after clear", 1'b1, fault_n);
        run_single(8'h10);
        u_host.send(1, cmd);
        tick(10);
        chk_pin("done after alt write", 1'b1, conv_done_n);
        cmd = '{mode: 2'h2, ch_en: 4'h3, diag_en: 4'h0, diag_rate: 1'b0};
        u_host.send(0, cmd);
        wait_done(1'b0, n);
        wait_done(1'b1, nl);
        chk_val("auto release", 64'(P_RDY), 64'(nl));
        wait_done(1'b0, nh);
        chk_val("sequence period", 64'(2 * P_SW + P_FAST + P_SLOW),
                64'(nl + nh));
        close_out();
    end
endmodule
